// ### verification/cmo_far_side_model.sv
// Far-side model: program flash and peripheral registers.
// Assumes both answer in the cycle of the read strobe.
`timescale 1ns/1ps
`default_nettype none
module cmo_far_side_model (
	input wire logic clk_i,
	input wire logic [14:0] pm_addr_i,
	input wire logic pm_rd_i,
	input wire logic [11:0] sfr_addr_i,
	input wire logic sfr_rd_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [13:0] pm_data_o,
	output logic [7:0] sfr_rdata_o
);
	// --------------------------------
	// Storage
	// --------------------------------
	logic [7:0] sfr_mem [0:4095];
	logic [13:0] idle_pat = 14'h1555;
	initial
		for (int i = 0; i < 4096; i++)
			sfr_mem[i] = 8'h00;
	// flash read only
	// Word mixes high bits in, so an unmasked address shows
	always @* pm_data_o = pm_rd_i ?
		{pm_addr_i[13:8], pm_addr_i[7:0] + {2'b00, pm_addr_i[13:8]}} : idle_pat;
	always_comb sfr_rdata_o = sfr_rd_i ? sfr_mem[sfr_addr_i] : ~idle_pat[7:0];
	always @(posedge clk_i)
	begin
		idle_pat <= ~idle_pat;
		if (sfr_wr_i)
			sfr_mem[sfr_addr_i] <= sfr_wdata_i;
	end
endmodule
`default_nettype wire

// ### verification/cmo_memory_org_checker.sv
// Checker for the core memory organisation block.
// Assumes a bind onto cmo_memory_org, one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module cmo_memory_org_checker #(
	parameter LARGE_VARIANT = 1'b0
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic [6:0] FA_I,
	input wire logic RD_I,
	input wire logic WR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic JUMP_I,
	input wire logic CALL_I,
	input wire logic IRQ_ENTRY_I,
	input wire logic [14:0] JUMP_ADDR_I,
	input wire logic STACK_RESET_EN_I,
	input wire logic ADD_EN_I,
	input wire logic ADD_SUB_I,
	input wire logic [7:0] ADD_A_I,
	input wire logic [7:0] ADD_B_I,
	input wire logic WATCHDOG_CLEAR_INSTRUCTION_I,
	input wire logic SLEEP_I,
	input wire logic WDT_TIMEOUT_I,
	input wire logic RVALID_O,
	input wire logic BUSY_O,
	input wire logic PM_RD_O,
	input wire logic [11:0] SFR_ADDR_O,
	input wire logic SFR_WR_O,
	input wire logic [7:0] SFR_WDATA_O,
	input wire logic [14:0] PC_O,
	input wire logic [7:0] STATUS_O,
	input wire logic [7:0] SUM_O,
	input wire logic STK_OVF_O,
	input wire logic SW_RESET_O
);
	// --------------------------------
	// Expected adder outcome
	// --------------------------------
	localparam [14:0] PC_MASK = LARGE_VARIANT ? 15'h3fff : 15'h1fff;
	wire [7:0] addend = ADD_SUB_I ? ~ADD_B_I : ADD_B_I;
	wire [8:0] sum9 = {1'b0, ADD_A_I} + {1'b0, addend} + {8'h00, ADD_SUB_I};
	wire [4:0] nib = {1'b0, ADD_A_I[3:0]} + {1'b0, addend[3:0]}
		+ {4'h0, ADD_SUB_I};
	wire [10:0] add_exp = {sum9[7:0], sum9[7:0] == 8'h00, nib[4], sum9[8]};
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);
	sequence s_answer;
		BUSY_O ##1 (RVALID_O && !BUSY_O);
	endsequence
	sequence s_sfr_take;
		WR_I && !RD_I && !BUSY_O && FA_I >= 7'h0c && FA_I <= 7'h1f;
	endsequence
	sequence s_pm_wait;
		BUSY_O ##1 (BUSY_O && !RVALID_O) ##1 (RVALID_O && !BUSY_O);
	endsequence
	// --------------------------------
	// Properties
	// --------------------------------
	// direct read timing
	a_read_answer: assert property (
		RD_I && !BUSY_O && FA_I > 7'h01 |=> s_answer)
		else $error("direct read answer missing");
	a_pm_extra: assert property (PM_RD_O |-> s_pm_wait)
		else $error("program read answer missing");
	a_sfr_write: assert property (s_sfr_take |=> SFR_WR_O &&
		SFR_WDATA_O == $past(WDATA_I) && SFR_ADDR_O[6:0] == $past(FA_I))
		else $error("peripheral write not passed on");
	a_pc_range: assert property ((PC_O & ~PC_MASK) == 15'h0000)
		else $error("program counter outside memory");
	a_jump_load: assert property (JUMP_I && !CALL_I && !IRQ_ENTRY_I
		|=> PC_O == ($past(JUMP_ADDR_I) & PC_MASK))
		else $error("jump target not loaded");
	a_irq_vector: assert property (IRQ_ENTRY_I |=> PC_O == 15'h0004)
		else $error("interrupt vector wrong");
	a_status_top: assert property (STATUS_O[7:5] == 3'h0)
		else $error("status top bits not zero");
	a_to_pd_hold: assert property (
		!WATCHDOG_CLEAR_INSTRUCTION_I && !SLEEP_I && !WDT_TIMEOUT_I |=> $stable(STATUS_O[4:3]))
		else $error("timeout or power-down bit moved");
	a_wdt_clear: assert property (WDT_TIMEOUT_I |=> !STATUS_O[4])
		else $error("timeout bit not cleared");
	a_sleep_clear: assert property (SLEEP_I |=> !STATUS_O[3])
		else $error("power-down bit not cleared");
	a_watchdog_clear_instruction_set: assert property (
		WATCHDOG_CLEAR_INSTRUCTION_I && !SLEEP_I && !WDT_TIMEOUT_I |=> STATUS_O[4:3] == 2'b11)
		else $error("reset status bits not set");
	a_adder_flags: assert property (
		ADD_EN_I |=> {SUM_O, STATUS_O[2:0]} == $past(add_exp))
		else $error("adder result or flags wrong");
	a_swreset_ovf: assert property (
		$rose(STK_OVF_O) && STACK_RESET_EN_I |-> ##[0:1] SW_RESET_O)
		else $error("no software reset on overflow");
	a_swreset_pulse: assert property (SW_RESET_O |=> !SW_RESET_O)
		else $error("software reset longer than one cycle");
endmodule
bind cmo_memory_org cmo_memory_org_checker #(
	.LARGE_VARIANT(LARGE_VARIANT)
) i_chk (.*);
`default_nettype wire

// ### verification/tb.sv
// Testbench for the core memory organisation block.
// Assumes the far-side model stands in for flash and peripherals.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// --------------------------------
	// Signals
	// --------------------------------
	localparam [8:0] E_INC = 9'h100, E_JMP = 9'h080, E_CALL = 9'h040;
	localparam [8:0] E_RET = 9'h020, E_IRQ = 9'h010, E_CLR = 9'h008;
	localparam [8:0] E_SLP = 9'h004, E_WDT = 9'h002, E_FCLR = 9'h001;
	logic SYS_CLK_I, RST_I, RD_I, WR_I, STACK_RESET_EN_I, ADD_EN_I;
	logic ADD_SUB_I;
	logic [6:0] FA_I;
	logic [7:0] WDATA_I, ADD_A_I, ADD_B_I;
	logic [2:0] FLAG_WE_I, FLAG_I;
	logic [14:0] JUMP_ADDR_I;
	logic [8:0] evs;
	wire PC_INC_I, JUMP_I, CALL_I, RET_I, IRQ_ENTRY_I, WATCHDOG_CLEAR_INSTRUCTION_I, SLEEP_I;
	wire WDT_TIMEOUT_I, STK_FLAG_CLR_I;
	wire [13:0] PM_DATA_I;
	wire [7:0] SFR_RDATA_I, RDATA_O, SFR_WDATA_O, STATUS_O, WORKING_REGISTER_O;
	wire [7:0] INTERRUPT_CONTROL_O, SUM_O;
	wire [14:0] PM_ADDR_O, PC_O;
	wire [11:0] SFR_ADDR_O;
	wire RVALID_O, BUSY_O, PM_RD_O, SFR_RD_O, SFR_WR_O;
	wire STK_OVF_O, STK_UNF_O, SW_RESET_O;
	int k, fail_count = 0, compares = 0;
	logic [31:0] seed;
	logic [7:0] w9;
	logic [7:0] q[$];
	assign {PC_INC_I, JUMP_I, CALL_I, RET_I, IRQ_ENTRY_I, WATCHDOG_CLEAR_INSTRUCTION_I, SLEEP_I,
		WDT_TIMEOUT_I, STK_FLAG_CLR_I} = evs;
	cmo_memory_org i_dut (.*);
	cmo_far_side_model i_far (.clk_i(SYS_CLK_I), .pm_addr_i(PM_ADDR_O),
		.pm_rd_i(PM_RD_O), .sfr_addr_i(SFR_ADDR_O), .sfr_rd_i(SFR_RD_O),
		.sfr_wr_i(SFR_WR_O), .sfr_wdata_i(SFR_WDATA_O),
		.pm_data_o(PM_DATA_I), .sfr_rdata_o(SFR_RDATA_I));
	always #20 SYS_CLK_I = ~SYS_CLK_I;
	// --------------------------------
	// Tasks
	// --------------------------------
	function automatic [31:0] lfsr(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] seen, exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step;
		@(posedge SYS_CLK_I);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		FA_I = a;
		WDATA_I = d;
		WR_I = 1'b1;
		step();
		WR_I = 1'b0;
		step();
	endtask
	// Reads block until the answer, bounded so a lost answer cannot hang
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		int n;
		q.push_back(e);
		FA_I = a;
		RD_I = 1'b1;
		step();
		RD_I = 1'b0;
		for (n = 0; n < 8 && RVALID_O !== 1'b1; n++)
			step();
		if (n == 8)
			fail_count++;
		step();
	endtask
	task automatic ptr(input logic [6:0] lo, input logic [15:0] v);
		wr(lo, v[7:0]);
		wr(lo + 7'h01, v[15:8]);
	endtask
	task automatic ev(input logic [8:0] v, input logic [14:0] a);
		evs = v;
		JUMP_ADDR_I = a;
		step();
		evs = 9'h000;
		step();
	endtask
	task automatic add(input logic [7:0] a, b, input logic sub, ws,
		input logic [7:0] w);
		logic [8:0] s9;
		logic [4:0] n5;
		s9 = {1'b0, a} + {1'b0, sub ? ~b : b} + {8'h00, sub};
		n5 = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + {4'h0, sub};
		{ADD_A_I, ADD_B_I, ADD_SUB_I, ADD_EN_I} = {a, b, sub, 1'b1};
		{FA_I, WDATA_I, WR_I} = {7'h03, w, ws};
		step();
		{ADD_EN_I, WR_I} = 2'b00;
		step();
		chk(SUM_O, s9[7:0], "sum");
		chk(STATUS_O[2:0], {s9[7:0] == 8'h00, n5[4], s9[8]}, "flags");
	endtask
	task automatic results;
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// --------------------------------
	// Result monitor
	// --------------------------------
	always @(posedge SYS_CLK_I)
		if (RVALID_O === 1'b1)
		begin
			if (q.size() == 0)
				fail_count++;
			else
				chk(RDATA_O, q.pop_front(), "rdata");
		end
	initial
	begin
		#160000;
		fail_count++;
		results();
	end
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial
	begin
		{SYS_CLK_I, RST_I, RD_I, WR_I, STACK_RESET_EN_I} = 5'h01 << 3;
		{ADD_EN_I, ADD_SUB_I, FLAG_WE_I, FLAG_I, evs} = 17'h00000;
		{FA_I, WDATA_I, ADD_A_I, ADD_B_I, JUMP_ADDR_I} = 46'h0;
		seed = 32'h16cef1fd;
		repeat (12) @(posedge SYS_CLK_I);
		#1;
		RST_I = 1'b0;
		chk(PC_O, 15'h0000, "pc");
		chk(STATUS_O, 8'h18, "status");
		for (k = 4; k < 12; k++)
		begin
			seed = lfsr(seed);
			wr(7'(k), seed[7:0]);
			rd(7'(k), seed[7:0] & (k == 8 ? 8'h1f : k == 10 ? 8'h7f : 8'hff));
			if (k == 9)
				w9 = seed[7:0];
		end
		chk(INTERRUPT_CONTROL_O, seed[7:0], "interrupt_control");
		wr(7'h08, 8'h00);
		wr(7'h20, 8'h5a);
		wr(7'h08, 8'h01);
		wr(7'h20, 8'ha5);
		wr(7'h75, 8'h3c);
		rd(7'h20, 8'ha5);
		wr(7'h08, 8'h00);
		rd(7'h20, 8'h5a);
		wr(7'h08, 8'hf4);
		rd(7'h08, 8'h14);
		rd(7'h75, 8'h3c);
		wr(7'h20, 8'h77);
		rd(7'h20, 8'h00);
		wr(7'h1f, 8'hc3);
		wr(7'h08, 8'h02);
		wr(7'h1f, 8'h3d);
		wr(7'h08, 8'h14);
		rd(7'h1f, 8'hc3);
		ptr(7'h06, 16'h2050);
		rd(7'h01, 8'ha5);
		ptr(7'h04, 16'h21df);
		wr(7'h00, 8'h9e);
		wr(7'h08, 8'h05);
		rd(7'h6f, 8'h9e);
		ptr(7'h04, 16'h21e0);
		rd(7'h00, 8'h00);
		ptr(7'h06, 16'ha123);
		rd(7'h01, 8'h24);
		ptr(7'h06, 16'h8020);
		wr(7'h01, 8'h11);
		ptr(7'h06, 16'h0020);
		rd(7'h01, 8'h5a);
		ev(E_JMP, 15'h7ffe);
		chk(PC_O, 15'h1ffe, "pc");
		ev(E_INC, 15'h0000);
		ev(E_INC, 15'h0000);
		chk(PC_O, 15'h0000, "pc");
		wr(7'h0a, 8'h65);
		wr(7'h02, 8'h40);
		chk(PC_O, 15'h0540, "pc");
		ev(E_IRQ, 15'h0000);
		chk(PC_O, 15'h0004, "pc");
		ev(E_RET, 15'h0000);
		chk(PC_O, 15'h0540, "pc");
		STACK_RESET_EN_I = 1'b1;
		for (k = 0; k < 16; k++)
			ev(E_CALL, 15'(16'h0200 + k));
		chk(STK_OVF_O, 1'b0, "ovf");
		ev(E_CALL, 15'h0300);
		chk(STK_OVF_O, 1'b1, "ovf");
		for (k = 15; k >= 0; k--)
		begin
			ev(E_RET, 15'h0000);
			chk(PC_O, k > 0 ? 15'(16'h01ff + k) : 15'h0540, "pc");
		end
		ev(E_RET, 15'h0000);
		chk({STK_UNF_O, PC_O}, 16'h8540, "unf");
		ev(E_FCLR, 15'h0000);
		chk({STK_OVF_O, STK_UNF_O}, 2'b00, "flags");
		wr(7'h03, 8'hff);
		chk(STATUS_O, 8'h1f, "status");
		wr(7'h03, 8'h00);
		chk(STATUS_O, 8'h18, "status");
		ev(E_WDT, 15'h0000);
		chk(STATUS_O[4:3], 2'b01, "to");
		ev(E_SLP, 15'h0000);
		chk(STATUS_O[4:3], 2'b10, "pd");
		ev(E_CLR, 15'h0000);
		chk(STATUS_O[4:3], 2'b11, "to");
		add(8'h05, 8'h05, 1'b1, 1'b1, 8'h00);
		for (k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			add(seed[7:0], seed[15:8], seed[16], seed[17], seed[25:18]);
		end
		// logic flag strobes beat file write
		{FLAG_WE_I, FLAG_I} = 6'b101_001;
		wr(7'h03, 8'h06);
		FLAG_WE_I = 3'h0;
		chk(STATUS_O[2:0], 3'b011, "flagwe");
		chk(WORKING_REGISTER_O, w9, "working_register");
		step();
		results();
	end
endmodule
`default_nettype wire

// ### verilog/cmo_consts.vh
// Constants for the core memory organisation block: core register
// offsets, data memory regions, status layout, vectors and stack size.
// Assumes a single include from the block's one design file.
`ifndef CMO_CONSTS_VH
`define CMO_CONSTS_VH

// ----------------------------------------------------------------
// Core register offsets inside every bank
// ----------------------------------------------------------------
`define CMO_OFS_IND0 7'h00
`define CMO_OFS_IND1 7'h01
`define CMO_OFS_PCL 7'h02
`define CMO_OFS_STATUS 7'h03
`define CMO_OFS_PTR0_LO 7'h04
`define CMO_OFS_PTR0_HI 7'h05
`define CMO_OFS_PTR1_LO 7'h06
`define CMO_OFS_PTR1_HI 7'h07
`define CMO_OFS_BSR 7'h08
`define CMO_OFS_WORKING_REGISTER 7'h09
`define CMO_OFS_PROGRAM_COUNTER_HIGH_LATCH 7'h0a
`define CMO_OFS_INTERRUPT_CONTROL 7'h0b

// ----------------------------------------------------------------
// Bank regions and RAM layout
// ----------------------------------------------------------------
`define CMO_SFR_FIRST 7'h0c
`define CMO_SFR_LAST 7'h1f
`define CMO_GPR_FIRST 7'h20
`define CMO_GPR_LAST 7'h6f
`define CMO_COMMON_FIRST 7'h70
`define CMO_GPR_BANK_BYTES 9'h050
`define CMO_GPR_BANKS 5'h06
`define CMO_RAM_COMMON_BASE 9'h1e0
`define CMO_RAM_LAST 495
`define CMO_LIN_BASE 16'h2000
`define CMO_LIN_END 16'h21e0
`define CMO_PM_SEL_BIT 15

// ----------------------------------------------------------------
// Status layout and reset values
// ----------------------------------------------------------------
`define CMO_ST_TO 4
`define CMO_ST_PD 3
`define CMO_ST_Z 2
`define CMO_ST_DC 1
`define CMO_ST_C 0
`define CMO_STATUS_RST 8'h18
`define CMO_BYTE_RST 8'h00

// ----------------------------------------------------------------
// Program counter and stack
// ----------------------------------------------------------------
`define CMO_PC_RESET 15'h0000
`define CMO_PC_IRQ 15'h0004
`define CMO_PC_MASK_SMALL 15'h1fff
`define CMO_PC_MASK_LARGE 15'h3fff
`define CMO_STACK_DEPTH 5'h10

// ----------------------------------------------------------------
// Access sequencer states
// ----------------------------------------------------------------
`define CMO_S_IDLE 2'h0
`define CMO_S_PM 2'h1
`define CMO_S_DATA 2'h2
`define CMO_S_PM_HOLD 2'h3

`endif

// ### verilog/cmo_memory_org.v
// Core memory organisation: return stack, program counter, indirect
// pointers, banked data memory decode, common RAM and status register.
// Assumes the fetch/execute logic drives one access at a time while
// BUSY_O is low, and that peripheral registers answer on SFR_RDATA_I
// in the same cycle that SFR_RD_O is high.
//
// Function
// RQ1 - Sixteen-entry fifteen-bit return stack
// RQ2 - Stack over/underflow flags, optional software reset
// RQ3 - Two 16-bit pointers reach everything, linearly; here the linear window 2000h-21DFh covers banked RAM only, not common RAM
// RQ4 - Program-space indirect read takes extra cycle
// RQ5 - Fifteen-bit program counter, 32K word space
// RQ6 - Program addresses wrap inside implemented memory
// RQ7 - Reset vector 0000h, interrupt vector 0004h
// RQ8 - Pointer bit 15 reads program word low byte
// RQ9 - Indirect writes never touch program memory
// RQ10 - 32 banks of 128 bytes, four regions
// RQ11 - Direct accesses use last written bank
// RQ12 - Unimplemented data locations read as zero
// RQ13 - 12-bit address: 5-bit bank, 7-bit offset
// RQ14 - First twelve offsets are shared core registers
// RQ15 - Offsets 0Ch-1Fh go to peripheral registers
// RQ16 - Sixteen common RAM bytes in every bank
// RQ17 - Flag-affecting instruction overrides status write
// RQ18 - Timeout/power-down read-only, bits 7-5 zero
// RQ19 - Timeout set by power-up/clear/sleep, cleared timeout
// RQ20 - Power-down set by power-up/clear, cleared sleep
// RQ21 - Zero, digit carry, carry; borrow inverted
// RQ22 - Software alters status with non-flag instructions
`include "cmo_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cmo_memory_org #(
	parameter LARGE_VARIANT = 1'b0
) (
	input wire SYS_CLK_I,
	input wire RST_I,
	input wire [6:0] FA_I,
	input wire RD_I,
	input wire WR_I,
	input wire [7:0] WDATA_I,
	input wire [13:0] PM_DATA_I,
	input wire [7:0] SFR_RDATA_I,
	input wire PC_INC_I,
	input wire JUMP_I,
	input wire CALL_I,
	input wire RET_I,
	input wire IRQ_ENTRY_I,
	input wire [14:0] JUMP_ADDR_I,
	input wire STACK_RESET_EN_I,
	input wire STK_FLAG_CLR_I,
	input wire ADD_EN_I,
	input wire ADD_SUB_I,
	input wire [7:0] ADD_A_I,
	input wire [7:0] ADD_B_I,
	input wire [2:0] FLAG_WE_I,
	input wire [2:0] FLAG_I,
	input wire WATCHDOG_CLEAR_INSTRUCTION_I,
	input wire SLEEP_I,
	input wire WDT_TIMEOUT_I,
	output reg [7:0] RDATA_O,
	output reg RVALID_O,
	output reg BUSY_O,
	output reg [14:0] PM_ADDR_O,
	output reg PM_RD_O,
	output reg [11:0] SFR_ADDR_O,
	output reg SFR_RD_O,
	output reg SFR_WR_O,
	output reg [7:0] SFR_WDATA_O,
	output reg [14:0] PC_O,
	output reg [7:0] STATUS_O,
	output reg [7:0] WORKING_REGISTER_O,
	output reg [7:0] INTERRUPT_CONTROL_O,
	output reg [7:0] SUM_O,
	output reg STK_OVF_O,
	output reg STK_UNF_O,
	output reg SW_RESET_O
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [7:0] ptr0_lo;
	reg [7:0] ptr0_hi;
	reg [7:0] ptr1_lo;
	reg [7:0] ptr1_hi;
	reg [7:0] bank_select;
	reg [7:0] pc_high_latch;
	reg [7:0] ram [0:`CMO_RAM_LAST];
	reg [14:0] stack_mem [0:15];
	reg [4:0] stk_cnt;
	reg [1:0] state;
	reg [11:0] req_addr;
	reg req_zero;
	reg req_ram;
	reg req_core;
	reg req_sfr;
	reg [8:0] req_idx;
	reg [7:0] pm_byte;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// RQ16 common RAM
	// Common bytes come first so every bank sees the same 16 cells.
	function ram_hit;
		input [11:0] a;
		begin
			ram_hit = (a[6:0] >= `CMO_COMMON_FIRST) ||
				((a[6:0] >= `CMO_GPR_FIRST) && (a[11:7] < `CMO_GPR_BANKS));
		end
	endfunction

	// RQ10 bank regions
	// Banked RAM is packed bank after bank, so the linear window
	// indexes the same array with no division.
	function [8:0] ram_idx;
		input [11:0] a;
		begin
			if (a[6:0] >= `CMO_COMMON_FIRST)
				ram_idx = `CMO_RAM_COMMON_BASE + {5'h00, a[3:0]};
			else
				ram_idx = ({4'h0, a[11:7]} * `CMO_GPR_BANK_BYTES) +
					({2'h0, a[6:0]} - {2'h0, `CMO_GPR_FIRST});
		end
	endfunction

	// ----------------------------------------------------------------
	// Address resolution
	// ----------------------------------------------------------------
	wire is_ind = (FA_I == `CMO_OFS_IND0) || (FA_I == `CMO_OFS_IND1);
	wire [15:0] ptr_sel = FA_I[0] ? {ptr1_hi, ptr1_lo} :
		{ptr0_hi, ptr0_lo};
	wire [15:0] lin_off = ptr_sel - `CMO_LIN_BASE;
	// RQ8 program space select
	wire ind_pm = is_ind && ptr_sel[`CMO_PM_SEL_BIT];
	// RQ3 linear window
	wire ind_lin = is_ind && !ind_pm && (ptr_sel >= `CMO_LIN_BASE) &&
		(ptr_sel < `CMO_LIN_END);
	wire ind_plain = is_ind && (ptr_sel < `CMO_LIN_BASE);
	// RQ11 bank from last write
	// RQ13 bank and offset split
	wire [11:0] res_addr = is_ind ? ptr_sel[11:0] :
		{bank_select[4:0], FA_I};
	// Pointing one indirect register at another yields zero, not a loop
	wire ind_loop = ind_plain && ((res_addr[6:0] == `CMO_OFS_IND0) ||
		(res_addr[6:0] == `CMO_OFS_IND1));
	// RQ12 unimplemented is zero
	wire res_zero = (is_ind && !ind_pm && !ind_lin && !ind_plain) ||
		ind_loop;
	wire res_direct = !res_zero && !ind_pm && !ind_lin;
	wire acc_ram = ind_lin || (res_direct && ram_hit(res_addr));
	wire [8:0] acc_idx = ind_lin ? lin_off[8:0] : ram_idx(res_addr);
	// RQ14 core register slots
	wire acc_core = res_direct && (res_addr[6:0] <= `CMO_OFS_INTERRUPT_CONTROL);
	// RQ15 peripheral slots
	wire acc_sfr = res_direct && (res_addr[6:0] >= `CMO_SFR_FIRST) &&
		(res_addr[6:0] <= `CMO_SFR_LAST);
	wire take = (RD_I || WR_I) && (state == `CMO_S_IDLE);
	wire do_wr = take && WR_I && !RD_I;
	wire do_rd = take && RD_I;
	wire core_wr = do_wr && acc_core;

	// ----------------------------------------------------------------
	// Adder and flags
	// ----------------------------------------------------------------
	// RQ21 flag generation
	// Subtraction adds the inverted operand plus one, so both carries
	// come out as inverted borrows without extra logic.
	wire [7:0] add_b = ADD_SUB_I ? ~ADD_B_I : ADD_B_I;
	wire add_cin = ADD_SUB_I;
	wire [4:0] low_sum = {1'b0, ADD_A_I[3:0]} + {1'b0, add_b[3:0]} +
		{4'h0, add_cin};
	wire [8:0] full_sum = {1'b0, ADD_A_I} + {1'b0, add_b} +
		{8'h00, add_cin};
	wire [2:0] alu_we = ADD_EN_I ? 3'h7 : FLAG_WE_I;
	wire [2:0] alu_val = ADD_EN_I ?
		{(full_sum[7:0] == 8'h00), low_sum[4], full_sum[8]} : FLAG_I;

	// ----------------------------------------------------------------
	// Program counter and stack control
	// ----------------------------------------------------------------
	reg [14:0] next_pc;
	reg push;
	reg pop;
	wire [14:0] pc_mask = LARGE_VARIANT ? `CMO_PC_MASK_LARGE :
		`CMO_PC_MASK_SMALL;
	wire stk_full = (stk_cnt == `CMO_STACK_DEPTH);
	wire stk_empty = (stk_cnt == 5'h00);
	wire [4:0] stk_below = stk_cnt - 5'h01;

	always @*
	begin
		next_pc = PC_O;
		push = 1'b0;
		pop = 1'b0;
		// RQ7 interrupt vector
		if (IRQ_ENTRY_I)
		begin
			next_pc = `CMO_PC_IRQ;
			push = 1'b1;
		end
		else if (CALL_I)
		begin
			next_pc = JUMP_ADDR_I;
			push = 1'b1;
		end
		else if (JUMP_I)
			next_pc = JUMP_ADDR_I;
		else if (RET_I)
		begin
			pop = 1'b1;
			if (!stk_empty)
				next_pc = stack_mem[stk_below[3:0]];
		end
		else if (core_wr && (res_addr[6:0] == `CMO_OFS_PCL))
			next_pc = {pc_high_latch[6:0], WDATA_I};
		else if (PC_INC_I)
			next_pc = PC_O + 15'h0001;
		// RQ6 wrap within memory
		next_pc = next_pc & pc_mask;
	end

	// RQ5 fifteen-bit counter
	// RQ7 reset vector
	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			PC_O <= `CMO_PC_RESET;
		else
			PC_O <= next_pc;
	end

	// RQ1 return stack
	// An overflowing push is dropped rather than wrapped so the
	// saved entries stay intact for a debugger after the reset.
	always @(posedge SYS_CLK_I)
	begin
		if (push && !stk_full)
			stack_mem[stk_cnt[3:0]] <= PC_O;
	end

	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			stk_cnt <= 5'h00;
			STK_OVF_O <= 1'b0;
			STK_UNF_O <= 1'b0;
			SW_RESET_O <= 1'b0;
		end
		else
		begin
			if (push && !stk_full)
				stk_cnt <= stk_cnt + 5'h01;
			else if (pop && !stk_empty)
				stk_cnt <= stk_below;
			// RQ2 overflow and underflow
			// Set wins over a clear in the same cycle.
			if (push && stk_full)
				STK_OVF_O <= 1'b1;
			else if (STK_FLAG_CLR_I)
				STK_OVF_O <= 1'b0;
			if (pop && stk_empty)
				STK_UNF_O <= 1'b1;
			else if (STK_FLAG_CLR_I)
				STK_UNF_O <= 1'b0;
			SW_RESET_O <= STACK_RESET_EN_I &&
				((push && stk_full) || (pop && stk_empty));
		end
	end

	// ----------------------------------------------------------------
	// Core register writes
	// ----------------------------------------------------------------
	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ptr0_lo <= `CMO_BYTE_RST;
			ptr0_hi <= `CMO_BYTE_RST;
			ptr1_lo <= `CMO_BYTE_RST;
			ptr1_hi <= `CMO_BYTE_RST;
			bank_select <= `CMO_BYTE_RST;
			pc_high_latch <= `CMO_BYTE_RST;
			WORKING_REGISTER_O <= `CMO_BYTE_RST;
			INTERRUPT_CONTROL_O <= `CMO_BYTE_RST;
		end
		else if (core_wr)
		begin
			case (res_addr[6:0])
				// RQ3 pointer registers
				`CMO_OFS_PTR0_LO: ptr0_lo <= WDATA_I;
				`CMO_OFS_PTR0_HI: ptr0_hi <= WDATA_I;
				`CMO_OFS_PTR1_LO: ptr1_lo <= WDATA_I;
				`CMO_OFS_PTR1_HI: ptr1_hi <= WDATA_I;
				// RQ11 bank select write
				`CMO_OFS_BSR: bank_select <= {3'h0, WDATA_I[4:0]};
				`CMO_OFS_WORKING_REGISTER: WORKING_REGISTER_O <= WDATA_I;
				`CMO_OFS_PROGRAM_COUNTER_HIGH_LATCH: pc_high_latch <= {1'b0, WDATA_I[6:0]};
				`CMO_OFS_INTERRUPT_CONTROL: INTERRUPT_CONTROL_O <= WDATA_I;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status register
	// ----------------------------------------------------------------
	wire st_wr = core_wr && (res_addr[6:0] == `CMO_OFS_STATUS);

	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			STATUS_O <= `CMO_STATUS_RST;
		else
		begin
			// RQ18 read-only upper bits
			STATUS_O[7:5] <= 3'h0;
			// RQ19 timeout bit
			if (WDT_TIMEOUT_I)
				STATUS_O[`CMO_ST_TO] <= 1'b0;
			else if (WATCHDOG_CLEAR_INSTRUCTION_I || SLEEP_I)
				STATUS_O[`CMO_ST_TO] <= 1'b1;
			// RQ20 power-down bit
			if (SLEEP_I)
				STATUS_O[`CMO_ST_PD] <= 1'b0;
			else if (WATCHDOG_CLEAR_INSTRUCTION_I)
				STATUS_O[`CMO_ST_PD] <= 1'b1;
			// RQ17 flags beat file write
			if (alu_we[2])
				STATUS_O[`CMO_ST_Z] <= alu_val[2];
			else if (st_wr)
				STATUS_O[`CMO_ST_Z] <= WDATA_I[`CMO_ST_Z];
			if (alu_we[1])
				STATUS_O[`CMO_ST_DC] <= alu_val[1];
			else if (st_wr)
				STATUS_O[`CMO_ST_DC] <= WDATA_I[`CMO_ST_DC];
			if (alu_we[0])
				STATUS_O[`CMO_ST_C] <= alu_val[0];
			else if (st_wr)
				STATUS_O[`CMO_ST_C] <= WDATA_I[`CMO_ST_C];
		end
	end

	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			SUM_O <= `CMO_BYTE_RST;
		else if (ADD_EN_I)
			SUM_O <= full_sum[7:0];
	end

	// ----------------------------------------------------------------
	// RAM writes
	// ----------------------------------------------------------------
	// RQ16 shared RAM write
	always @(posedge SYS_CLK_I)
	begin
		if (do_wr && acc_ram)
			ram[acc_idx] <= WDATA_I;
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	reg [7:0] core_rd;

	always @*
	begin
		case (req_addr[6:0])
			`CMO_OFS_PCL: core_rd = PC_O[7:0];
			`CMO_OFS_STATUS: core_rd = STATUS_O;
			`CMO_OFS_PTR0_LO: core_rd = ptr0_lo;
			`CMO_OFS_PTR0_HI: core_rd = ptr0_hi;
			`CMO_OFS_PTR1_LO: core_rd = ptr1_lo;
			`CMO_OFS_PTR1_HI: core_rd = ptr1_hi;
			`CMO_OFS_BSR: core_rd = bank_select;
			`CMO_OFS_WORKING_REGISTER: core_rd = WORKING_REGISTER_O;
			`CMO_OFS_PROGRAM_COUNTER_HIGH_LATCH: core_rd = pc_high_latch;
			`CMO_OFS_INTERRUPT_CONTROL: core_rd = INTERRUPT_CONTROL_O;
			default: core_rd = `CMO_BYTE_RST;
		endcase
	end

	always @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state <= `CMO_S_IDLE;
			req_addr <= 12'h000;
			req_zero <= 1'b0;
			req_ram <= 1'b0;
			req_core <= 1'b0;
			req_sfr <= 1'b0;
			req_idx <= 9'h000;
			pm_byte <= `CMO_BYTE_RST;
			RDATA_O <= `CMO_BYTE_RST;
			RVALID_O <= 1'b0;
			BUSY_O <= 1'b0;
			PM_ADDR_O <= 15'h0000;
			PM_RD_O <= 1'b0;
			SFR_ADDR_O <= 12'h000;
			SFR_RD_O <= 1'b0;
			SFR_WR_O <= 1'b0;
			SFR_WDATA_O <= `CMO_BYTE_RST;
		end
		else
		begin
			RVALID_O <= 1'b0;
			PM_RD_O <= 1'b0;
			SFR_RD_O <= 1'b0;
			SFR_WR_O <= 1'b0;
			case (state)
				`CMO_S_IDLE:
				begin
					req_addr <= res_addr;
					req_zero <= res_zero;
					req_ram <= acc_ram;
					req_core <= acc_core;
					req_sfr <= acc_sfr;
					req_idx <= acc_idx;
					// RQ15 peripheral write strobe
					if (do_wr && acc_sfr)
					begin
						SFR_ADDR_O <= res_addr;
						SFR_WDATA_O <= WDATA_I;
						SFR_WR_O <= 1'b1;
					end
					// RQ9 no program writes
					// A write through a program pointer falls through
					// every strobe above and is simply dropped.
					if (do_rd && ind_pm)
					begin
						// RQ4 extra fetch cycle
						PM_ADDR_O <= ptr_sel[14:0] & pc_mask;
						PM_RD_O <= 1'b1;
						BUSY_O <= 1'b1;
						state <= `CMO_S_PM;
					end
					else if (do_rd)
					begin
						SFR_ADDR_O <= res_addr;
						SFR_RD_O <= acc_sfr;
						BUSY_O <= 1'b1;
						state <= `CMO_S_DATA;
					end
				end
				`CMO_S_PM:
				begin
					// RQ8 low byte of word
					pm_byte <= PM_DATA_I[7:0];
					state <= `CMO_S_PM_HOLD;
				end
				`CMO_S_PM_HOLD:
				begin
					// RQ4 extra answer cycle
					// Held back one cycle so a program read costs one more
					// cycle than a data read, as the fetch does in the core.
					RDATA_O <= pm_byte;
					RVALID_O <= 1'b1;
					BUSY_O <= 1'b0;
					state <= `CMO_S_IDLE;
				end
				`CMO_S_DATA:
				begin
					// RQ12 zero for empty slots
					if (req_zero)
						RDATA_O <= `CMO_BYTE_RST;
					else if (req_ram)
						RDATA_O <= ram[req_idx];
					else if (req_core)
						RDATA_O <= core_rd;
					else if (req_sfr)
						RDATA_O <= SFR_RDATA_I;
					else
						RDATA_O <= `CMO_BYTE_RST;
					RVALID_O <= 1'b1;
					BUSY_O <= 1'b0;
					state <= `CMO_S_IDLE;
				end
				default:
				begin
					BUSY_O <= 1'b0;
					state <= `CMO_S_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire
